// [ict_pkg.sv]
/*
  Package for the second interrupt-control block: register offsets, field
  positions, reset values and the packed carriers shared by the files.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package ict_pkg;

  // Byte offsets of the registers on the APB.
  localparam logic [7:0] ICT_CTRL2_OFS  = 8'h00;  // Interrupt control two.
  localparam logic [7:0] ICT_STAT_OFS   = 8'h04;  // Sticky event status.
  localparam logic [7:0] ICT_MASK_OFS   = 8'h08;  // Interrupt mask.
  localparam logic [7:0] ICT_CHGEN_OFS  = 8'h0C;  // Per-pin change enables.
  localparam logic [7:0] ICT_PULLEN_OFS = 8'h10;  // Per-pin pull-up enables.
  localparam logic [7:0] ICT_DIR_OFS    = 8'h14;  // Pin input selects.
  localparam logic [7:0] ICT_PORT_A_DATA_OFS  = 8'h18;  // Port A data, read only.
  localparam logic [7:0] ICT_PORT_B_DATA_OFS  = 8'h1C;  // Port B data, read only.

  // Field positions inside interrupt control two.
  localparam int ICT_PUD_BIT  = 7;
  localparam int ICT_EDG0_BIT = 6;
  localparam int ICT_EDG1_BIT = 5;
  localparam int ICT_EDG2_BIT = 4;
  localparam int ICT_T0P_BIT  = 2;
  localparam int ICT_CHP_BIT  = 0;

  // Implemented bits, and their value after reset.
  localparam logic [7:0] ICT_CTRL2_MASK  = 8'hF5;
  localparam logic [7:0] ICT_CTRL2_RESET = 8'hF5;

  // Status bit positions: three external inputs and the port change.
  localparam int ICT_ST_EXT0 = 0;
  localparam int ICT_ST_EXT1 = 1;
  localparam int ICT_ST_EXT2 = 2;
  localparam int ICT_ST_CHG  = 3;
  localparam int ICT_ST_W    = 4;

  // Reset values of the other registers.
  localparam logic [3:0]  ICT_ZERO4  = 4'h0;
  localparam logic [7:0]  ICT_ZERO8  = 8'h00;
  localparam logic [15:0] ICT_ZERO16 = 16'h0000;
  localparam logic [15:0] ICT_ONES16 = 16'hFFFF;

  // APB request carrier.
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ict_apb_req_t;

  // Control-two fields as a carrier.
  typedef struct packed {
    logic pullup_disable;
    logic edge0;
    logic edge1;
    logic edge2;
    logic unused3;
    logic t0_prio;
    logic unused1;
    logic chg_prio;
  } ict_ctrl2_t;

endpackage

// [ict_edge_det.sv]
/*
  Edge detector for the external interrupt inputs, one per input through a
  generate loop. Assumes the inputs are already synchronous to the clock.
*/
`timescale 1ns/1ps
module ict_edge_det
  import ict_pkg::*;
#(
  parameter int N = 3
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [N-1:0] pin_in,
  input  wire logic [N-1:0] rising_in,
  output logic      [N-1:0] hit_out
);

  logic [N-1:0] prev_ff;  // Last sampled level of each input.

  // Keep the previous level so one clock of history gives the edge.
  // In reset the live level is loaded. A pin that idles high then shows
  // no false falling edge on the first clock after reset lifts.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      prev_ff <= pin_in;
    end else begin
      prev_ff <= pin_in;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_edge
      // Rising when the select is one, falling when it is zero.
      assign hit_out[g] = rising_in[g] ? (pin_in[g] & ~prev_ff[g])
                                       : (~pin_in[g] & prev_ff[g]);
    end
  endgenerate

endmodule // ict_edge_det

// [ict_ctrl.sv]
/*
  Second interrupt-control register with its APB slave, pull-up gating,
  external-edge events, port-change detection and the interrupt outputs.
  Assumes a single 20 MHz clock and port pins synchronous to that clock.
*/
`timescale 1ns/1ps
module ict_ctrl
  import ict_pkg::*;
(
  input  wire logic        MCLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [2:0]  EXT_IRQ_IN,
  input  wire logic [7:0]  PORT_A_IN,
  input  wire logic [7:0]  PORT_B_IN,
  input  wire logic        TIMER0_OVF_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  output logic [15:0]      PULLUP_EN_OUT,
  output logic             IRQ_OUT,
  output logic             IRQ_HIGH_OUT,
  output logic             IRQ_LOW_OUT
);

  // Bundled request, so decoding reads from one carrier.
  ict_apb_req_t req;
  assign req = '{sel: PSEL_IN, enable: PENABLE_IN, write: PWRITE_IN,
                 addr: PADDR_IN, wdata: PWDATA_IN};

  // Stored registers.
  logic [7:0]  ctrl2_ff;       // Interrupt control two, implemented bits only.
  logic [3:0]  stat_ff;        // Sticky event status.
  logic [3:0]  mask_ff;        // Interrupt mask, one enables.
  logic [15:0] chg_en_ff;      // Per-pin change enables, port B high byte.
  logic [15:0] pull_en_ff;     // Per-pin pull-up enables.
  logic [15:0] dir_in_ff;      // One marks a pin as an input.
  logic [7:0]  latch_a_ff;     // Port A level at its last read.
  logic [7:0]  latch_b_ff;     // Port B level at its last read.
  logic [31:0] prdata_ff;      // Registered read data.
  logic        pready_ff;      // Registered ready.
  logic        pslverr_ff;     // Registered error.
  logic [15:0] pullup_ff;      // Registered pull-up drive.
  logic        irq_ff;         // Registered combined interrupt.
  logic        irq_hi_ff;      // Registered high-priority request.
  logic        irq_lo_ff;      // Registered low-priority request.
  ict_ctrl2_t  c2;             // Field view of control two.
  assign c2 = ctrl2_ff;

  // Access phase decode. Ready is a registered answer, so every access
  // takes exactly one wait state; this keeps PRDATA straight from a flop.
  wire acc      = req.sel & req.enable & ~pready_ff;
  wire wr_acc   = acc & req.write;
  wire rd_acc   = acc & ~req.write;
  wire hit_c2   = (req.addr == ICT_CTRL2_OFS);
  wire hit_st   = (req.addr == ICT_STAT_OFS);
  wire hit_mk   = (req.addr == ICT_MASK_OFS);
  wire hit_ce   = (req.addr == ICT_CHGEN_OFS);
  wire hit_pe   = (req.addr == ICT_PULLEN_OFS);
  wire hit_dr   = (req.addr == ICT_DIR_OFS);
  wire hit_pa   = (req.addr == ICT_PORT_A_DATA_OFS);
  wire hit_pb   = (req.addr == ICT_PORT_B_DATA_OFS);
  wire mapped   = hit_c2 | hit_st | hit_mk | hit_ce | hit_pe | hit_dr
                | hit_pa | hit_pb;
  // Port data is read only, so a write there is an error as well.
  wire bad      = ~mapped | (req.write & (hit_pa | hit_pb));

  // Write strobes, one per plain writable register, so each flop block
  // reads a single named enable instead of repeating the decode.
  wire wr_mk    = wr_acc & hit_mk;
  wire wr_ce    = wr_acc & hit_ce;
  wire wr_pe    = wr_acc & hit_pe;
  wire wr_dr    = wr_acc & hit_dr;
  // Port reads are what end a mismatch, so they get their own strobes.
  wire rd_pa    = rd_acc & hit_pa;
  wire rd_pb    = rd_acc & hit_pb;

  // External edge events with polarity from control two.
  logic [2:0] ext_hit;
  wire  [2:0] edge_sel = {c2.edge2, c2.edge1, c2.edge0};

  ict_edge_det #(
    .N (3)
  ) u_edge (
    .clk_in    (MCLK_IN),
    .rst_b_in  (RST_B_IN),
    .pin_in    (EXT_IRQ_IN),
    .rising_in (edge_sel),
    .hit_out   (ext_hit)
  );

  // A pin mismatches while its level differs from the level latched at the
  // last port read and its own change enable is set. The condition persists
  // until software reads the port, so the flag keeps being set meanwhile.
  wire [15:0] live     = {PORT_B_IN, PORT_A_IN};
  wire [15:0] latched  = {latch_b_ff, latch_a_ff};
  wire [15:0] mism_pin = (live ^ latched) & chg_en_ff;
  wire        mismatch = |mism_pin;

  // Events gathered at their status positions.
  wire [3:0] events = {mismatch, ext_hit};

  // Write-one-to-clear, but a new event in the same cycle wins.
  wire [3:0] st_clr = (wr_acc & hit_st) ? req.wdata[3:0] : ICT_ZERO4;
  wire [3:0] nxt_stat = (stat_ff & ~st_clr) | events;

  // Only implemented bits are stored, so unused positions keep no state.
  wire [7:0] nxt_ctrl2 = (wr_acc & hit_c2) ? (req.wdata[7:0] & ICT_CTRL2_MASK)
                                           : ctrl2_ff;

  // Read multiplexer; unused control bits are never stored and read zero.
  wire [31:0] rd_mux =
      hit_c2 ? {24'h000000, ctrl2_ff & ICT_CTRL2_MASK} :
      hit_st ? {28'h0000000, stat_ff} :
      hit_mk ? {28'h0000000, mask_ff} :
      hit_ce ? {16'h0000, chg_en_ff} :
      hit_pe ? {16'h0000, pull_en_ff} :
      hit_dr ? {16'h0000, dir_in_ff} :
      hit_pa ? {24'h000000, PORT_A_IN} :
      hit_pb ? {24'h000000, PORT_B_IN} : 32'h00000000;

  // Pull-up gating: global disable overrides everything.
  wire [15:0] nxt_pullup = c2.pullup_disable ? ICT_ZERO16
                                             : (pull_en_ff & dir_in_ff);

  // Priority steering. The change request follows its status bit; the
  // timer overflow has no status here, so its level passes straight through.
  wire pend_chg  = stat_ff[ICT_ST_CHG] & mask_ff[ICT_ST_CHG];
  wire pend_ext  = |(stat_ff[2:0] & mask_ff[2:0]);
  wire hi_req    = (pend_chg & c2.chg_prio)
                 | (TIMER0_OVF_IN & c2.t0_prio)
                 | pend_ext;
  wire lo_req    = (pend_chg & ~c2.chg_prio)
                 | (TIMER0_OVF_IN & ~c2.t0_prio);

  // Control two and its reset value of all ones in the used bits.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      ctrl2_ff <= ICT_CTRL2_RESET;
    end else begin
      ctrl2_ff <= nxt_ctrl2;
    end
  end

  // Sticky status. The next value already lets a new event win over a
  // clear in the same cycle, so an event landing on the clear is kept.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      stat_ff <= ICT_ZERO4;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // Interrupt mask, same layout as status; reset leaves every status source off.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      mask_ff <= ICT_ZERO4;
    end else if (wr_mk) begin
      mask_ff <= req.wdata[3:0];
    end
  end

  // Per-pin change enables. They start clear, so no pin can mismatch
  // until software has picked the pins it cares about.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      chg_en_ff <= ICT_ZERO16;
    end else if (wr_ce) begin
      chg_en_ff <= req.wdata[15:0];
    end
  end

  // Per-pin pull-up enables, only honoured while the global disable is off.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      pull_en_ff <= ICT_ZERO16;
    end else if (wr_pe) begin
      pull_en_ff <= req.wdata[15:0];
    end
  end

  // Input selects. Every pin starts as an input, the safe state for a pin
  // whose use is not yet known, since nothing is then driven against it.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      dir_in_ff <= ICT_ONES16;
    end else if (wr_dr) begin
      dir_in_ff <= req.wdata[15:0];
    end
  end

  // A port A read re-latches its level, which ends that port's mismatch.
  // A pin that keeps toggling afterwards starts a fresh mismatch at once.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      latch_a_ff <= ICT_ZERO8;
    end else if (rd_pa) begin
      latch_a_ff <= PORT_A_IN;
    end
  end

  // The same for port B; only a port that holds a mismatching pin must be read to end the mismatch.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      latch_b_ff <= ICT_ZERO8;
    end else if (rd_pb) begin
      latch_b_ff <= PORT_B_IN;
    end
  end

  // Ready answers one cycle after the access is taken and stands for one
  // cycle; the blocked decode keeps it from answering the same access twice.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= acc;
    end
  end

  // Error goes out with ready for an unmapped address or a write to
  // read-only port data; such a write changes nothing.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= acc & bad;
    end
  end

  // Read data is zero outside the answer cycle of a read, so a stale value
  // never lingers on the bus for a later master to misread.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      prdata_ff <= 32'h00000000;
    end else begin
      prdata_ff <= rd_acc ? rd_mux : 32'h00000000;
    end
  end

  // Pull-up drive. It follows the settings one cycle late, which is far
  // below the settling time of any weak pull-up.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      pullup_ff <= ICT_ZERO16;
    end else begin
      pullup_ff <= nxt_pullup;
    end
  end

  // Combined interrupt level. It lags status by one cycle; that cost buys
  // an output straight from a flop with no decode glitches.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  // High-priority request: external events, and the change or timer
  // sources whose priority bit is one.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      irq_hi_ff <= 1'b0;
    end else begin
      irq_hi_ff <= hi_req;
    end
  end

  // Low-priority request: the change or timer sources whose priority bit
  // is zero. Each source lands on exactly one of the two outputs.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      irq_lo_ff <= 1'b0;
    end else begin
      irq_lo_ff <= lo_req;
    end
  end

  assign PRDATA_OUT    = prdata_ff;
  assign PREADY_OUT    = pready_ff;
  assign PSLVERR_OUT   = pslverr_ff;
  assign PULLUP_EN_OUT = pullup_ff;
  assign IRQ_OUT       = irq_ff;
  assign IRQ_HIGH_OUT  = irq_hi_ff;
  assign IRQ_LOW_OUT   = irq_lo_ff;

endmodule // ict_ctrl

// [ict_ctrl_props.sv]
/*
  Checker for the interrupt control block, watching only its top ports.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ict_ctrl_props
  import ict_pkg::*;
(
  input wire logic        MCLK_IN,
  input wire logic        RST_B_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic        TIMER0_OVF_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic [15:0] PULLUP_EN_OUT,
  input wire logic        IRQ_HIGH_OUT,
  input wire logic        IRQ_LOW_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // An access is taken in its first access cycle.
  wire       take     = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
  wire [7:0] nxt_ctrl = PWDATA_IN[7:0] & ICT_CTRL2_MASK;
  logic [7:0] ctrl_ff;  // Shadow of control two, same timing as the design.
  wire pu_off = ctrl_ff[ICT_PUD_BIT];  // Shadowed pull-up disable.
  wire t0_hi  = ctrl_ff[ICT_T0P_BIT];  // Shadowed timer priority.
  // The shadow lets the priority checks know the bits without seeing the body.
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) ctrl_ff <= ICT_CTRL2_RESET;
    else if (take & PWRITE_IN & (PADDR_IN == ICT_CTRL2_OFS)) ctrl_ff <= nxt_ctrl;
  end
  a_ready_wait: assert property (take |=> PREADY_OUT) else $error("ready late");
  a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready long");
  a_ready_idle: assert property (!PSEL_IN |=> !PREADY_OUT) else $error("ready unasked");
  a_rdata_quiet: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0) else $error("rdata");
  a_err_unmapped: assert property (PREADY_OUT && $past(PADDR_IN) > 8'h1C |-> PSLVERR_OUT)
    else $error("no error");
  a_ctrl_read: assert property (PREADY_OUT && !$past(PWRITE_IN) &&
    $past(PADDR_IN) == ICT_CTRL2_OFS |-> PRDATA_OUT == {24'h0, ctrl_ff})
    else $error("ctrl read");
  a_pullup_off: assert property (pu_off && $past(pu_off) |->
    PULLUP_EN_OUT == 16'h0000) else $error("pullup on");
  a_timer_high: assert property ($past(RST_B_IN) && $past(TIMER0_OVF_IN) && $past(t0_hi)
    |-> IRQ_HIGH_OUT) else $error("timer high");
  a_timer_low: assert property ($past(RST_B_IN) && $past(TIMER0_OVF_IN) && !$past(t0_hi)
    |-> IRQ_LOW_OUT) else $error("timer low");
endmodule // ict_ctrl_props
bind ict_ctrl ict_ctrl_props u_ict_ctrl_props (.MCLK_IN, .RST_B_IN, .PSEL_IN, .PENABLE_IN,
  .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .TIMER0_OVF_IN, .PRDATA_OUT, .PREADY_OUT,
  .PSLVERR_OUT, .PULLUP_EN_OUT, .IRQ_HIGH_OUT, .IRQ_LOW_OUT);

// [ict_ctrl_test.sv]
/*
  Self-checking bench for the interrupt control block.
  Assumes the bench drives every port itself, as an APB master.
*/
`timescale 1ns/1ps
module ict_ctrl_test;
  import ict_pkg::*;
  logic        clk = 0, rst_b = 0, psel, penable, pwrite, tmr, err;
  logic [7:0]  paddr, pa, pb;
  logic [31:0] pwdata, q, v, prdata;
  logic [31:0] seed = 32'h00005660;  // Fixed seed keeps runs repeatable.
  logic [2:0]  ext;
  logic [15:0] pull;
  logic        ready, slverr, irq, irq_hi, irq_lo;
  int          fail_count = 0, n_checks = 0;
  ict_ctrl u_ict_ctrl (.MCLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .EXT_IRQ_IN(ext), .PORT_A_IN(pa), .PORT_B_IN(pb), .TIMER0_OVF_IN(tmr),
    .PRDATA_OUT(prdata), .PREADY_OUT(ready), .PSLVERR_OUT(slverr),
    .PULLUP_EN_OUT(pull), .IRQ_OUT(irq), .IRQ_HIGH_OUT(irq_hi), .IRQ_LOW_OUT(irq_lo));
  initial forever #25 clk = ~clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; the wait ends only on ready or the watchdog.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (ready !== 1'b1);
    q = prdata;
    err = slverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // A hang counts as a mismatch and ends the run the normal way.
  initial begin
    tick(20000);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ext, pa, pb, tmr} = '0;
    tick(4);
    rst_b <= 1'b1;
    apb(0, ICT_CTRL2_OFS, 0); check("ctrl2", q, 32'hF5);
    check("pullup", pull, 32'h0);
    // The first value sets only the unused bits, a corner case.
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 32'h0A : xs();
      apb(1, ICT_CTRL2_OFS, v);
      apb(0, ICT_CTRL2_OFS, 0); check("ctrl2", q, {24'h0, v[7:0] & ICT_CTRL2_MASK});
      check("err", err, 0);
    end
    v = xs();
    apb(1, ICT_PULLEN_OFS, {16'h0, v[15:0]});
    apb(1, ICT_DIR_OFS, {16'h0, v[31:16]});
    for (int p = 0; p < 2; p++) begin
      apb(1, ICT_CTRL2_OFS, p ? 32'h85 : 32'h05); tick(2);
      check("pullup", pull, p ? 32'h0 : v[15:0] & v[31:16]);
    end
    apb(1, ICT_MASK_OFS, 32'hF);
    // Each input, each polarity: the right edge sets, the wrong one does not.
    for (int i = 0; i < 3; i++) for (int p = 0; p < 2; p++) begin
      apb(1, ICT_CTRL2_OFS, p ? 32'hF5 : 32'h85);
      ext <= p ? 3'b000 : 3'b111; tick(3);
      apb(1, ICT_STAT_OFS, 32'hF);
      ext[i] <= p; tick(3);
      apb(0, ICT_STAT_OFS, 0); check("status", q, 32'h1 << i);
      check("irq", irq, 1);
      check("irq_high", irq_hi, 1);
      apb(1, ICT_STAT_OFS, 32'hF);
      ext[i] <= !p; tick(3);
      apb(0, ICT_STAT_OFS, 0); check("status", q, 0);
      check("irq", irq, 0);
      check("irq_high", irq_hi, 0);
    end
    apb(1, ICT_MASK_OFS, 32'h8);
    pa <= 8'h01; tick(3);
    apb(0, ICT_STAT_OFS, 0); check("status", q, 0);
    apb(1, ICT_CHGEN_OFS, 32'h1); tick(3);
    apb(0, ICT_STAT_OFS, 0); check("status", q, 32'h8);
    apb(1, ICT_STAT_OFS, 32'h8);
    apb(0, ICT_STAT_OFS, 0); check("status", q, 32'h8);
    for (int p = 0; p < 2; p++) begin
      apb(1, ICT_CTRL2_OFS, p ? 32'h81 : 32'h80); tick(2);
      check("irq_high", irq_hi, p);
      check("irq_low", irq_lo, !p);
    end
    apb(0, ICT_PORT_A_DATA_OFS, 0);
    apb(0, ICT_PORT_B_DATA_OFS, 0);
    apb(1, ICT_STAT_OFS, 32'h8); tick(2);
    apb(0, ICT_STAT_OFS, 0); check("status", q, 0);
    apb(1, ICT_MASK_OFS, 0);
    tmr <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      apb(1, ICT_CTRL2_OFS, p ? 32'h84 : 32'h80); tick(2);
      check("irq_high", irq_hi, p);
      check("irq_low", irq_lo, !p);
    end
    tmr <= 1'b0;
    apb(0, 8'h40, 0); check("err", err, 1);
    check("rdata", q, 0);
    apb(1, ICT_PORT_A_DATA_OFS, 1); check("err", err, 1);
    tally_and_finish();
  end
endmodule // ict_ctrl_test
